// ==== hdl/intc_defines.vh ====
// register offsets, field positions and reset values of the interrupt block
`ifndef INTC_DEFINES_VH
`define INTC_DEFINES_VH
`define NUM_SRC        16
`define OFS_FLAGS      12'h000
`define OFS_ENABLES    12'h004
`define OFS_PRIO_LO    12'h008
`define OFS_PRIO_HI    12'h00C
`define OFS_STATUS     12'h010
`define OFS_CORE       12'h014
`define OFS_CTL_ONE    12'h018
`define OFS_PENDING    12'h01C
`define IPL_LSB        5
`define IPL_TOP_BIT    3
`define NEST_BIT       15
`define OVA_BIT        14
`define OVB_BIT        13
`define COVA_BIT       12
`define COVB_BIT       11
`define OVA_TE_BIT     10
`define OVB_TE_BIT     9
`define COV_TE_BIT     8
`define SHIFT_BIT      7
`define DIV0_BIT       6
`define MATH_BIT       4
`define ADDR_BIT       3
`define STACK_BIT      2
`define OSC_BIT        1
`define CTL_ONE_WMASK  16'h8700
`define RST_WORD16     16'h0000
`define IPL_ALL_MASKED 3'h7
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ==== hdl/sticky_flag.v ====
// one sticky event flag, set by hardware, cleared by software write
`timescale 1ns/1ps
module sticky_flag (
    input  wire aclk,
    input  wire aresetn,
    input  wire set_evt,
    input  wire clr_req,
    output reg  flag
);
    // set wins over a clear in the same cycle so no event is lost
    always @(posedge aclk) begin
        if (!aresetn)
            flag <= 1'b0;
        else if (set_evt)
            flag <= 1'b1;
        else if (clr_req)
            flag <= 1'b0;
    end
endmodule // sticky_flag

// ==== hdl/interrupt_priority_and_trap_status.v ====
// interrupt priority, cpu level and trap status block with axi4-lite port
`timescale 1ns/1ps
`include "intc_defines.vh"
module interrupt_priority_and_trap_status (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [15:0] source_event,
    input  wire        int_taken,
    input  wire        handler_return,
    input  wire        trap_entry,
    input  wire        acc_a_overflow_evt,
    input  wire        acc_b_overflow_evt,
    input  wire        acc_a_severe_evt,
    input  wire        acc_b_severe_evt,
    input  wire        bad_shift_evt,
    input  wire        divide_zero_evt,
    input  wire        address_fault_evt,
    input  wire        stack_fault_evt,
    input  wire        oscillator_fault_evt,
    output reg         cpu_irq,
    output reg         cpu_wake,
    output reg         acc_overflow_trap
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    wire [15:0] request_flag_regs;
    reg  [15:0] source_enable_regs;
    reg  [47:0] source_priority_regs;
    reg  [2:0]  cpu_level_low_bits;
    reg         cpu_level_top_bit;
    reg         nesting_lockout;
    reg  [2:0]  trap_enables;
    reg  [6:0]  pending_vector_number;
    reg  [3:0]  pending_level;
    reg  [2:0]  saved_level;
    wire [9:0]  trap_flags;
    reg  [11:0] wr_addr;
    reg  [31:0] wr_data;
    reg  [3:0]  wr_strb;
    reg         have_aw;
    reg         have_w;
    wire [3:0]  cpu_level = {cpu_level_top_bit, cpu_level_low_bits};
    // ------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------
    wire do_write = have_aw && have_w && !s_axi_bvalid;
    wire wr_lo    = do_write && wr_strb[0];
    wire wr_hi    = do_write && wr_strb[1];
    wire wr_mapped = (wr_addr <= `OFS_PENDING);
    always @(posedge aclk) begin
        if (!aresetn) begin
            have_aw       <= 1'b0;
            have_w        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            wr_addr       <= 12'h000;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !have_w && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                have_aw      <= 1'b0;
                have_w       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // request flags: one sticky cell per source
    // ------------------------------------------------------------
    wire flag_wr = wr_lo && wr_hi && (wr_addr == `OFS_FLAGS);
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SRC; gi = gi + 1) begin : g_flag
            sticky_flag u_flag (
                .aclk    (aclk),
                .aresetn (aresetn),
                .set_evt (source_event[gi]),
                .clr_req (flag_wr && !wr_data[gi]),
                .flag    (request_flag_regs[gi])
            );
        end
    endgenerate
    // ------------------------------------------------------------
    // trap cause flags, cleared by writing zero to control one
    // ------------------------------------------------------------
    wire ctl_wr = wr_lo && wr_hi && (wr_addr == `OFS_CTL_ONE);
    wire [9:0] trap_set = {acc_a_overflow_evt & trap_enables[2],
        acc_b_overflow_evt & trap_enables[1],
        acc_a_severe_evt & trap_enables[0],
        acc_b_severe_evt & trap_enables[0],
        bad_shift_evt, divide_zero_evt,
        bad_shift_evt | divide_zero_evt,
        address_fault_evt, stack_fault_evt, oscillator_fault_evt};
    wire [9:0] trap_wbit = {wr_data[`OVA_BIT], wr_data[`OVB_BIT],
        wr_data[`COVA_BIT], wr_data[`COVB_BIT], wr_data[`SHIFT_BIT],
        wr_data[`DIV0_BIT], wr_data[`MATH_BIT], wr_data[`ADDR_BIT],
        wr_data[`STACK_BIT], wr_data[`OSC_BIT]};
    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : g_trap
            sticky_flag u_trap (
                .aclk    (aclk),
                .aresetn (aresetn),
                .set_evt (trap_set[gi]),
                .clr_req (ctl_wr && !trap_wbit[gi]),
                .flag    (trap_flags[gi])
            );
        end
    endgenerate
    // ------------------------------------------------------------
    // arbitration: highest priority, lowest vector wins
    // ------------------------------------------------------------
    reg [2:0] best_prio;
    reg [6:0] best_vec;
    integer   i;
    always @* begin
        best_prio = 3'h0;
        best_vec  = 7'h00;
        for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
            // scanning downward with >= lets lower vectors win ties
            if (request_flag_regs[i] && source_enable_regs[i] &&
                    source_priority_regs[3*i +: 3] != 3'h0 &&
                    source_priority_regs[3*i +: 3] >= best_prio) begin
                best_prio = source_priority_regs[3*i +: 3];
                best_vec  = i[6:0];
            end
        end
    end
    // strict compare against full 4-bit level, so top bit blocks all
    wire want_irq = ({1'b0, best_prio} > cpu_level);
    // ------------------------------------------------------------
    // cpu level, enables, priorities and trap enables
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            source_enable_regs    <= `RST_WORD16;
            source_priority_regs  <= 48'h0000_0000_0000;
            cpu_level_low_bits    <= 3'h0;
            cpu_level_top_bit     <= 1'b0;
            nesting_lockout       <= 1'b0;
            trap_enables          <= 3'h0;
            pending_vector_number <= 7'h00;
            pending_level         <= 4'h0;
            saved_level           <= 3'h0;
            cpu_irq               <= 1'b0;
            cpu_wake              <= 1'b0;
            acc_overflow_trap     <= 1'b0;
        end else begin
            cpu_irq  <= want_irq;
            cpu_wake <= (best_prio != 3'h0);
            acc_overflow_trap <= |trap_set[9:6];
            if (want_irq) begin
                pending_vector_number <= best_vec;
                pending_level         <= {1'b0, best_prio};
            end
            // top bit set by trap entry, cleared by handler return; no software path
            if (trap_entry)
                cpu_level_top_bit <= 1'b1;
            else if (handler_return)
                cpu_level_top_bit <= 1'b0;
            if (int_taken) begin
                saved_level <= cpu_level_low_bits;
                if (nesting_lockout)
                    cpu_level_low_bits <= `IPL_ALL_MASKED;
                else
                    cpu_level_low_bits <= pending_level[2:0];
            end else if (handler_return) begin
                cpu_level_low_bits <= saved_level;
            end else if (wr_lo && wr_addr == `OFS_STATUS &&
                    !nesting_lockout) begin
                cpu_level_low_bits <= wr_data[`IPL_LSB +: 3];
            end
            if (wr_lo && wr_hi && wr_addr == `OFS_ENABLES)
                source_enable_regs <= wr_data[15:0];
            if (wr_lo && wr_hi && wr_addr == `OFS_PRIO_LO)
                source_priority_regs[23:0] <= wr_data[23:0];
            if (wr_lo && wr_hi && wr_addr == `OFS_PRIO_HI)
                source_priority_regs[47:24] <= wr_data[23:0];
            if (ctl_wr) begin
                nesting_lockout <= wr_data[`NEST_BIT];
                trap_enables <= {wr_data[`OVA_TE_BIT],
                    wr_data[`OVB_TE_BIT], wr_data[`COV_TE_BIT]};
            end
        end
    end
    // ------------------------------------------------------------
    // read channel, one cycle after address taken
    // ------------------------------------------------------------
    reg [31:0] rd_word;
    reg        rd_ok;
    always @* begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (s_axi_araddr == `OFS_FLAGS)
            rd_word[15:0] = request_flag_regs;
        else if (s_axi_araddr == `OFS_ENABLES)
            rd_word[15:0] = source_enable_regs;
        else if (s_axi_araddr == `OFS_PRIO_LO)
            rd_word[23:0] = source_priority_regs[23:0];
        else if (s_axi_araddr == `OFS_PRIO_HI)
            rd_word[23:0] = source_priority_regs[47:24];
        else if (s_axi_araddr == `OFS_STATUS)
            rd_word[`IPL_LSB +: 3] = cpu_level_low_bits;
        else if (s_axi_araddr == `OFS_CORE)
            rd_word[`IPL_TOP_BIT] = cpu_level_top_bit;
        else if (s_axi_araddr == `OFS_CTL_ONE)
            rd_word[15:0] = {nesting_lockout, trap_flags[9:6],
                trap_enables, trap_flags[5:4], 1'b0, trap_flags[3:0],
                1'b0};
        else if (s_axi_araddr == `OFS_PENDING)
            rd_word[15:0] = {4'h0, pending_level, 1'b0,
                pending_vector_number};
        else
            rd_ok = 1'b0;
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // interrupt_priority_and_trap_status

// ==== verif/intc_props.sv ====
// port assertions of the interrupt priority and trap status block
`timescale 1ns/1ps
module intc_props (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        handler_return,
    input logic        trap_entry,
    input logic        acc_a_overflow_evt,
    input logic        acc_b_overflow_evt,
    input logic        acc_a_severe_evt,
    input logic        acc_b_severe_evt,
    input logic        cpu_irq,
    input logic        cpu_wake,
    input logic        acc_overflow_trap
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // any accumulator event; the check lets the trap follow it by one or two edges
    wire acc_ev = acc_a_overflow_evt | acc_b_overflow_evt |
                  acc_a_severe_evt | acc_b_severe_evt;
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
    property p_awready;
        s_axi_awready |-> s_axi_awvalid;
    endproperty
    a_awready: assert property (p_awready) else $error("stray awready");
    property p_wready;
        s_axi_wready |-> s_axi_wvalid;
    endproperty
    a_wready: assert property (p_wready) else $error("stray wready");
    property p_quiet;
        !$past(aresetn) |-> !cpu_irq && !cpu_wake && !s_axi_bvalid &&
            !s_axi_rvalid && !acc_overflow_trap;
    endproperty
    a_quiet: assert property (p_quiet) else $error("output busy at reset");
    property p_irq_wake;
        cpu_irq |-> cpu_wake;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("irq, no wake");
    property p_trap_mask;
        trap_entry && !handler_return ##1 !handler_return |-> ##1 !cpu_irq;
    endproperty
    a_trap_mask: assert property (p_trap_mask) else $error("irq in trap");
    property p_acc_trap;
        acc_overflow_trap |-> $past(acc_ev) || $past(acc_ev, 2);
    endproperty
    a_acc_trap: assert property (p_acc_trap) else $error("stray trap");
endmodule // intc_props
bind interrupt_priority_and_trap_status intc_props i_props (.*);

// ==== verif/cpu_core_model.sv ====
// cpu core stand-in: takes the request, later returns from the handler
`timescale 1ns/1ps
module cpu_core_model (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       cpu_irq,
    input  wire       allow,
    input  wire [3:0] lag,
    output logic      int_taken,
    output logic      handler_return
);
    int   cnt;
    logic busy;
    // lag makes the core prompt or slow; stay of 40 leaves room for reads
    always @(posedge aclk) begin
        int_taken <= 0;
        handler_return <= 0;
        if (!aresetn) begin
            busy <= 0;
            cnt <= 0;
        end else if (!busy) begin
            cnt <= (cpu_irq && allow) ? cnt + 1 : 0;
            if (cpu_irq && allow && cnt >= lag) begin
                int_taken <= 1;
                busy <= 1;
                cnt <= 0;
            end
        end else begin
            cnt <= cnt + 1;
            if (cnt == 40) begin
                handler_return <= 1;
                busy <= 0;
            end
        end
    end
endmodule // cpu_core_model

// ==== verif/test_interrupt_priority_and_trap_status.sv ====
// self-checking bench of the interrupt priority and trap status block
`timescale 1ns/1ps
`include "intc_defines.vh"
module test_interrupt_priority_and_trap_status;
    logic        aclk = 0, aresetn = 0, allow = 0, trap_entry = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q, m, w, seed = 32'h415e;
    logic [3:0]  s_axi_wstrb = 4'hF, lag = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] source_event = 0;
    logic [8:0]  ev = 0;
    logic        int_taken, handler_return, cpu_irq, cpu_wake;
    logic        acc_overflow_trap;
    int          err_total = 0, num_checks = 0, prio[16], best, win, lvl;
    int          pos[9] = '{14, 13, 12, 11, 7, 6, 3, 2, 1};
    wire acc_a_overflow_evt = ev[0], acc_b_overflow_evt = ev[1];
    wire acc_a_severe_evt = ev[2], acc_b_severe_evt = ev[3];
    wire bad_shift_evt = ev[4], divide_zero_evt = ev[5];
    wire address_fault_evt = ev[6], stack_fault_evt = ev[7];
    wire oscillator_fault_evt = ev[8];
    interrupt_priority_and_trap_status i_dut (.*);
    cpu_core_model i_cpu (.*);
    initial forever #5 aclk = ~aclk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(logic [31:0] g, logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task timeout(int n);
        if (n >= 99) begin
            err_total++;
            $display("[ERR] %0t wait ran out", $time);
            report_and_stop;
        end
    endtask
    // ready comes late at random so the slave must hold its answer
    task automatic wr(logic [11:0] a, logic [31:0] d);
        int n = 0;
        int r = 1 + rnd() % 4;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (n == r) s_axi_bready <= 1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 99);
        resp = s_axi_bresp;
        s_axi_bready <= 0;
        timeout(n);
    endtask
    task automatic rd(logic [11:0] a);
        int n = 0;
        int r = 1 + rnd() % 4;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (n == r) s_axi_rready <= 1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 99);
        q = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
        timeout(n);
    endtask
    task pulse(logic [15:0] v);
        source_event <= v;
        @(posedge aclk);
        source_event <= 0;
    endtask
    // winner: highest nonzero priority, lowest index on a tie
    task pick(logic [15:0] en);
        best = 0;
        win = 0;
        for (int i = 15; i >= 0; i--)
            if (en[i] && prio[i] > 0 && prio[i] >= best) begin
                best = prio[i];
                win = i;
            end
    endtask
    task automatic take(bit locked);
        int n = 0;
        allow <= 1;
        for (n = 0; !int_taken && n < 99; n++) @(posedge aclk);
        allow <= 0;
        timeout(n);
        rd(`OFS_PENDING);
        chk(q[11:0], {best[3:0], 1'b0, win[6:0]});
        rd(`OFS_STATUS);
        chk(q[7:5], locked ? 7 : best);
        for (n = 0; !handler_return && n < 99; n++) @(posedge aclk);
        timeout(n);
        rd(`OFS_STATUS);
        chk(q[7:5], lvl);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        for (int a = 0; a <= 32; a += 4) begin
            rd(12'(a));
            chk(resp, a > 28 ? `RESP_SLVERR : `RESP_OKAY);
            if (a < 32) chk(q, `RST_WORD16);
        end
        wr(12'h020, 32'h0000_0001);
        chk(resp, `RESP_SLVERR);
        m = rnd();
        pulse(m[15:0]);
        rd(`OFS_FLAGS);
        chk(q, {16'h0000, m[15:0]});
        w = rnd();
        wr(`OFS_FLAGS, w);
        rd(`OFS_FLAGS);
        chk(q, {16'h0000, m[15:0] & w[15:0]});
        for (int h = 0; h < 2; h++) begin
            m = 0;
            for (int i = 0; i < 8; i++) begin
                prio[8*h+i] = rnd() % 8;
                m[3*i +: 3] = 3'(prio[8*h+i]);
            end
            wr(12'(`OFS_PRIO_LO + 4 * h), m);
            rd(12'(`OFS_PRIO_LO + 4 * h));
            chk(q, m);
        end
        pulse(16'hFFFF);
        for (int k = 0; k < 8; k++) begin
            m = rnd();
            lvl = k;
            lag <= 4'(rnd());
            wr(`OFS_ENABLES, m);
            rd(`OFS_ENABLES);
            chk(q, m & 32'h0000_FFFF);
            wr(`OFS_STATUS, lvl << 5);
            pick(m[15:0]);
            repeat (3) @(posedge aclk);
            chk(cpu_irq, best > lvl);
            chk(cpu_wake, best > 0);
            if (best > lvl) take(0);
        end
        lvl = 0;
        wr(`OFS_STATUS, 0);
        wr(`OFS_CTL_ONE, 32'h0000_8000);
        wr(`OFS_STATUS, 32'h0000_0060);
        rd(`OFS_STATUS);
        chk(q[7:5], 0);
        wr(`OFS_ENABLES, 32'h0000_FFFF);
        pick(16'hFFFF);
        if (best > 0) take(1);
        wr(`OFS_CORE, 32'h0000_0008);
        rd(`OFS_CORE);
        chk(q[3], 0);
        for (int e = 0; e < 18; e++) begin
            m = e[0] ? 32'h0000_0700 : 0;
            wr(`OFS_CTL_ONE, m);
            ev <= 9'(1 << (e / 2));
            @(posedge aclk);
            ev <= 0;
            @(posedge aclk);
            chk(acc_overflow_trap, e < 8 && e[0]);
            if (e >= 8 || e[0]) m[pos[e/2]] = 1;
            if (e / 2 == 4 || e / 2 == 5) m[4] = 1;
            rd(`OFS_CTL_ONE);
            chk(q, m);
        end
        trap_entry <= 1;
        @(posedge aclk);
        trap_entry <= 0;
        rd(`OFS_CORE);
        chk(q[3], 1);
        chk(cpu_irq, 0);
        report_and_stop;
    end
endmodule // test_interrupt_priority_and_trap_status
